// [verilog/clock_network_dynamic_mux.sv]
// dynamic clock multiplexers, local network selectors and tree enables
// Overview of operation
// - eight dynamic multiplexers feed the global signals, two per side.
// - when enabled, a user select bus chooses the active input at run time.
// - after configuration every multiplexer selects input 0.
// - each core local network takes up to 16 signals from global, fabric or regional sources.
// - top and bottom local networks take 8 regional signals, others take 4.
// - core regions are 80 cells tall with local networks of 40 cells per column.
// - local fabric may drive local clocks and per-cell clock enables directly.
// - top and bottom interface regions take 14 global and 2 fabric clocks.
// - side interface regions take up to 4 clocks with at most 2 from fabric.
// - the fifth PLL output reaches only the top or bottom regional network.
// - an alternate-input pin may feed a PLL reference directly.
// - there are 32 global signals, usable as clock or control.
// - each tree has a glitch-free dynamic enable.
`timescale 1ns/10ps
`default_nettype none
module clock_network_dynamic_mux
  import clk_net_pkg::*;
#(
  parameter int N_MUX = NUM_DYN_MUX,
  parameter int N_IN = MUX_INPUTS,
  parameter int SW = SEL_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [N_MUX*N_IN-1:0] mux_clk_in,
  input wire logic [N_MUX-1:0] mux_enable,
  input wire logic [N_MUX*SW-1:0] mux_sel,
  input wire logic [NUM_GLOBAL-1:0] global_tree_enable,
  input wire logic [NUM_GLOBAL-1:0] global_src,
  input wire logic [NUM_FABRIC-1:0] fabric_src,
  input wire logic [REGIONAL_TB-1:0] regional_src,
  input wire logic [LOCAL_SIGNALS*6-1:0] local_pick,
  input wire logic local_is_top_bottom,
  input wire logic [LOCAL_SIGNALS-1:0] fabric_cell_ce,
  input wire logic pll_fifth_output_clock,
  input wire logic pll_fifth_to_top,
  input wire logic alt_pin_in,
  input wire logic [TB_GLOBAL_CLOCKS*$clog2(NUM_GLOBAL)-1:0] tb_if_pick,
  input wire logic [LR_MAX_CLOCKS*6-1:0] lr_if_pick,
  output logic [N_MUX-1:0] mux_clk_en,
  output logic [N_MUX*SW-1:0] mux_active_sel,
  output logic [N_MUX-1:0] mux_switching,
  output logic [NUM_GLOBAL-1:0] global_tree_on,
  output logic [LOCAL_SIGNALS-1:0] local_net,
  output logic [LOCAL_SIGNALS-1:0] cell_ce,
  output logic regional_top_pll,
  output logic regional_bottom_pll,
  output logic pll_ref_clk,
  output logic [TB_MAX_CLOCKS-1:0] tb_if_clk,
  output logic [LR_MAX_CLOCKS-1:0] lr_if_clk
);
  localparam int GSEL_W = $clog2(NUM_GLOBAL);
  // ********************
  // synchronisers for pin-side inputs
  // ********************
  logic [N_MUX*N_IN-1:0] clk_s1, clk_s2;
  logic [N_MUX*SW-1:0] sel_s1, sel_s2;
  logic [N_MUX-1:0] en_s1, en_s2;
  logic [NUM_GLOBAL-1:0] gsrc_s1, gsrc_s2;
  logic [NUM_FABRIC-1:0] fsrc_s1, fsrc_s2;
  logic [REGIONAL_TB-1:0] rsrc_s1, rsrc_s2;
  logic pll_s1, pll_s2, alt_s1, alt_s2;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_s1 <= '0;
      clk_s2 <= '0;
      sel_s1 <= '0;
      sel_s2 <= '0;
      en_s1 <= '0;
      en_s2 <= '0;
      gsrc_s1 <= '0;
      gsrc_s2 <= '0;
      fsrc_s1 <= '0;
      fsrc_s2 <= '0;
      rsrc_s1 <= '0;
      rsrc_s2 <= '0;
      pll_s1 <= 1'b0;
      pll_s2 <= 1'b0;
      alt_s1 <= 1'b0;
      alt_s2 <= 1'b0;
    end else begin
      clk_s1 <= mux_clk_in;
      clk_s2 <= clk_s1;
      sel_s1 <= mux_sel;
      sel_s2 <= sel_s1;
      en_s1 <= mux_enable;
      en_s2 <= en_s1;
      gsrc_s1 <= global_src;
      gsrc_s2 <= gsrc_s1;
      fsrc_s1 <= fabric_src;
      fsrc_s2 <= fsrc_s1;
      rsrc_s1 <= regional_src;
      rsrc_s2 <= rsrc_s1;
      pll_s1 <= pll_fifth_output_clock;
      pll_s2 <= pll_s1;
      alt_s1 <= alt_pin_in;
      alt_s2 <= alt_s1;
    end
  end

  // ********************
  // dynamic multiplexers
  // ********************
  genvar m;
  generate
    for (m = 0; m < N_MUX; m++) begin : g_mux
      sw_state_t state, next_state;
      logic [SW-1:0] cur, next_cur, pend, next_pend;
      logic [1:0] wait_cnt, next_wait_cnt;
      logic run, next_run;
      logic [SW-1:0] req;
      logic cur_lvl;
      assign req = en_s2[m] ? sel_s2[m*SW +: SW] : SEL_RESET;
      assign cur_lvl = clk_s2[m*N_IN + int'(cur)];
      always_comb begin
        next_state = state;
        next_cur = cur;
        next_pend = pend;
        next_wait_cnt = wait_cnt;
        next_run = run;
        case (state)
          SW_IDLE: begin
            next_run = 1'b1;
            if (req != cur) begin
              next_pend = req;
              next_state = SW_STOP;
            end
          end
          SW_STOP: begin
            if (!cur_lvl) begin
              next_run = 1'b0;
              next_cur = pend;
              next_wait_cnt = 2'(SW_WAIT_CYCLES);
              next_state = SW_WAIT;
            end
          end
          SW_WAIT: begin
            if (wait_cnt == 2'h0) begin
              next_state = SW_START;
            end else begin
              next_wait_cnt = wait_cnt - 2'h1;
            end
          end
          SW_START: begin
            if (!cur_lvl) begin
              next_run = 1'b1;
              next_state = SW_IDLE;
            end
          end
          default: begin
            next_state = SW_IDLE;
          end
        endcase
      end
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          state <= SW_IDLE;
          cur <= SEL_RESET;
          pend <= SEL_RESET;
          wait_cnt <= 2'h0;
          run <= 1'b0;
        end else begin
          state <= next_state;
          cur <= next_cur;
          pend <= next_pend;
          wait_cnt <= next_wait_cnt;
          run <= next_run;
        end
      end
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          mux_active_sel[m*SW +: SW] <= SEL_RESET;
          mux_switching[m] <= 1'b0;
        end else begin
          mux_active_sel[m*SW +: SW] <= next_cur;
          mux_switching[m] <= (next_state != SW_IDLE);
        end
      end
      clk_gate_cell u_gate (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .req_en(next_run),
        .gate_en(mux_clk_en[m])
      );
    end
  endgenerate

  // ********************
  // global tree enables and local network
  // ********************
  function automatic logic pick_src(input logic [5:0] code, input logic tb,
                                    input logic [NUM_GLOBAL-1:0] g, input logic [NUM_FABRIC-1:0] f,
                                    input logic [REGIONAL_TB-1:0] r);
    logic v;
    v = 1'b0;
    if (code < 6'd32) begin
      v = g[code[4:0]];
    end else if (code < 6'd48) begin
      v = f[code[3:0]];
    end else if (tb || code[2] == 1'b0) begin
      v = r[code[2:0]];
    end
    return v;
  endfunction
  logic [LOCAL_SIGNALS-1:0] next_local_net;
  always_comb begin
    for (int i = 0; i < LOCAL_SIGNALS; i++) begin
      next_local_net[i] = pick_src(local_pick[i*6 +: 6], local_is_top_bottom, gsrc_s2, fsrc_s2, rsrc_s2);
    end
  end

  // ********************
  // interface region clocks
  // ********************
  logic [TB_MAX_CLOCKS-1:0] next_tb_if_clk;
  logic [LR_MAX_CLOCKS-1:0] next_lr_if_clk;
  always_comb begin
    next_tb_if_clk = '0;
    next_lr_if_clk = '0;
    for (int i = 0; i < TB_GLOBAL_CLOCKS; i++) begin
      next_tb_if_clk[i] = gsrc_s2[tb_if_pick[i*GSEL_W +: GSEL_W]];
    end
    for (int i = 0; i < TB_FABRIC_CLOCKS; i++) begin
      next_tb_if_clk[TB_GLOBAL_CLOCKS+i] = fsrc_s2[i];
    end
    // only the low slots may take a fabric code
    for (int i = 0; i < LR_MAX_CLOCKS; i++) begin
      if (i < LR_FABRIC_CLOCKS || lr_if_pick[i*6+4 +: 2] != 2'b10) begin
        next_lr_if_clk[i] = pick_src(lr_if_pick[i*6 +: 6], 1'b0, gsrc_s2, fsrc_s2, rsrc_s2);
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      global_tree_on <= '0;
      local_net <= '0;
      cell_ce <= '0;
      regional_top_pll <= 1'b0;
      regional_bottom_pll <= 1'b0;
      pll_ref_clk <= 1'b0;
      tb_if_clk <= '0;
      lr_if_clk <= '0;
    end else begin
      global_tree_on <= global_tree_enable;
      local_net <= next_local_net;
      cell_ce <= fabric_cell_ce;
      regional_top_pll <= pll_s2 & pll_fifth_to_top;
      regional_bottom_pll <= pll_s2 & ~pll_fifth_to_top;
      pll_ref_clk <= alt_s2;
      tb_if_clk <= next_tb_if_clk;
      lr_if_clk <= next_lr_if_clk;
    end
  end
endmodule // clock_network_dynamic_mux
`default_nettype wire

// [verilog/clk_net_pkg.sv]
// package: constants for the dynamic clock multiplexer network
`default_nettype none
package clk_net_pkg;
  localparam int NUM_DYN_MUX = 8;
  localparam int MUX_PER_SIDE = 2;
  localparam int MUX_INPUTS = 4;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam int NUM_GLOBAL = 32;
  localparam int NUM_FABRIC = 16;
  localparam int LOCAL_SIGNALS = 16;
  localparam int REGIONAL_TB = 8;
  localparam int REGIONAL_SIDE = 4;
  localparam int REGION_CELLS = 80;
  localparam int LOCAL_CELLS = 40;
  localparam int TB_MAX_CLOCKS = 16;
  localparam int TB_GLOBAL_CLOCKS = 14;
  localparam int TB_FABRIC_CLOCKS = 2;
  localparam int LR_MAX_CLOCKS = 4;
  localparam int LR_FABRIC_CLOCKS = 2;
  localparam int SW_WAIT_CYCLES = 2;
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_STOP = 2'b01,
    SW_WAIT = 2'b10,
    SW_START = 2'b11
  } sw_state_t;
endpackage
`default_nettype wire

// [verilog/clk_gate_cell.sv]
// gated enable cell for the output of one dynamic multiplexer
`timescale 1ns/10ps
`default_nettype none
module clk_gate_cell (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_en,
  output logic gate_en
);
  logic en_q;
  logic next_en_q;
  // ********************
  // enable register
  // ********************
  always_comb begin
    next_en_q = req_en;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= next_en_q;
    end
  end
  assign gate_en = en_q;
endmodule // clk_gate_cell
`default_nettype wire

// [sim/src_clk_model.sv]
// partner model: user logic that feeds toggling clocks to every mux input
`timescale 1ns/10ps
`default_nettype none
module src_clk_model (
  input wire logic ref_clk,
  output logic [31:0] clk_out
);
  int cnt = 0;
  // *****
  // every input is driven low at the first ref_clk falling edge, then toggles at one of five slow rates
  // *****
  always @(negedge ref_clk) begin
    cnt++;
    for (int i = 0; i < 32; i++) clk_out[i] = 1'((cnt / (i % 5 + 2)) % 2);
  end
endmodule // src_clk_model
`default_nettype wire

// [sim/clock_network_dynamic_mux_assertions.sv]
// checker: port assertions for the clock network
`timescale 1ns/10ps
`default_nettype none
module clock_network_dynamic_mux_chk
  import clk_net_pkg::*;
#(parameter int N_MUX = NUM_DYN_MUX, parameter int N_IN = MUX_INPUTS, parameter int SW = SEL_W) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [N_MUX-1:0] mux_clk_en,
  input wire logic [N_MUX*SW-1:0] mux_active_sel,
  input wire logic [N_MUX-1:0] mux_switching,
  input wire logic [NUM_GLOBAL-1:0] global_tree_enable,
  input wire logic [NUM_GLOBAL-1:0] global_tree_on,
  input wire logic [LOCAL_SIGNALS-1:0] fabric_cell_ce,
  input wire logic [LOCAL_SIGNALS-1:0] cell_ce,
  input wire logic pll_fifth_to_top,
  input wire logic regional_top_pll,
  input wire logic regional_bottom_pll,
  input wire logic alt_pin_in,
  input wire logic pll_ref_clk
);
  // *****
  // assertions
  // *****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_tree_on_rise: assert property ($rose(global_tree_enable[0]) |-> ##1 global_tree_on[0])
    else $error("tree not on");
  a_tree_off: assert property (!global_tree_enable[1] [*6] |-> !global_tree_on[1])
    else $error("tree not off");
  a_cell_ce_path: assert property (cell_ce == $past(fabric_cell_ce, 1)) else $error("cell ce");
  a_pll_ref_path: assert property (pll_ref_clk == $past(alt_pin_in, 3)) else $error("pll ref");
  a_fifth_top_only: assert property (regional_top_pll |-> $past(pll_fifth_to_top, 1))
    else $error("fifth top");
  a_fifth_bot_only: assert property (regional_bottom_pll |-> !$past(pll_fifth_to_top, 1))
    else $error("fifth bottom");
  a_switch_stop: assert property ($rose(mux_switching[0]) |-> ##[1:40] !mux_clk_en[0])
    else $error("old clock not stopped");
  a_switch_end: assert property ($rose(mux_switching[0]) |-> ##[1:60] !mux_switching[0])
    else $error("switch hung");
  a_sel_gated: assert property ($changed(mux_active_sel[SW-1:0]) |-> ##[0:1] !mux_clk_en[0])
    else $error("select moved while gated on");
  cover property ($rose(mux_switching[0]));
  cover property ($rose(regional_top_pll));
  cover property ($fell(global_tree_on[0]));
endmodule // clock_network_dynamic_mux_chk
bind clock_network_dynamic_mux clock_network_dynamic_mux_chk #(.N_MUX(N_MUX), .N_IN(N_IN), .SW(SW)) u_chk (
  .ref_clk, .rstn, .mux_clk_en, .mux_active_sel, .mux_switching, .global_tree_enable, .global_tree_on,
  .fabric_cell_ce, .cell_ce, .pll_fifth_to_top, .regional_top_pll, .regional_bottom_pll, .alt_pin_in, .pll_ref_clk);
`default_nettype wire

// [sim/test_clock_network_dynamic_mux.sv]
// testbench: self-checking bench for the clock network
`timescale 1ns/10ps
`default_nettype none
module test_clock_network_dynamic_mux;
  import clk_net_pkg::*;
  logic ref_clk = 0, rstn = 0, local_is_top_bottom = 0, pll_fifth_output_clock = 0, pll_fifth_to_top = 0;
  logic alt_pin_in = 0, regional_top_pll, regional_bottom_pll, pll_ref_clk;
  logic [31:0] mux_clk_in, global_tree_enable = 0, global_src = 0, global_tree_on;
  logic [15:0] mux_sel = 0, fabric_src = 0, fabric_cell_ce = 0, mux_active_sel, local_net, cell_ce, tb_if_clk;
  logic [7:0] mux_enable = 0, regional_src = 0, mux_clk_en, mux_switching, sw_mask;
  logic [95:0] local_pick = 0;
  logic [69:0] tb_if_pick = 0;
  logic [23:0] lr_if_pick = 0;
  logic [3:0] lr_if_clk;
  int n_fail = 0, tests_run = 0, k, j, idx;
  int exp_sel[8], prev_sel[8];
  // *****
  // design, partner and clock
  // *****
  clock_network_dynamic_mux u_clock_network_dynamic_mux (.ref_clk, .rstn, .mux_clk_in, .mux_enable, .mux_sel,
    .global_tree_enable, .global_src, .fabric_src, .regional_src, .local_pick, .local_is_top_bottom, .fabric_cell_ce,
    .pll_fifth_output_clock, .pll_fifth_to_top, .alt_pin_in, .tb_if_pick, .lr_if_pick, .mux_clk_en, .mux_active_sel,
    .mux_switching, .global_tree_on, .local_net, .cell_ce, .regional_top_pll, .regional_bottom_pll, .pll_ref_clk,
    .tb_if_clk, .lr_if_clk);
  src_clk_model u_src_clk_model (.ref_clk, .clk_out(mux_clk_in));
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int code);
    if (code < 32) return global_src[code];
    if (code < 48) return fabric_src[code - 32];
    if (!local_is_top_bottom && code[2]) return 1'b0;
    return regional_src[code[2:0]];
  endfunction
  function automatic logic lr_pick(input int slot, input int code);
    if (code < 32) return global_src[code];
    if (code < 48) return (slot < LR_FABRIC_CLOCKS) ? fabric_src[code - 32] : 1'b0;
    if (code[2]) return 1'b0;
    return regional_src[code[1:0]];
  endfunction
  task automatic wait_idle(input logic [7:0] exp_sw);
    cyc(4);
    chk(mux_switching, exp_sw);
    idx = 0;
    while (mux_switching !== 8'h00 && idx < 400) begin
      cyc(1);
      idx++;
    end
    if (idx >= 400) n_fail++;
    cyc(3);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // *****
  // tests
  // *****
  initial begin
    void'($urandom(53));
    cyc(6);
    rstn = 1;
    cyc(4);
    chk(mux_active_sel, 16'h0000);
    chk(mux_clk_en, 8'hff);
    for (k = 0; k < 6; k++) begin
      global_tree_enable = $urandom;
      global_src = $urandom;
      fabric_src = $urandom;
      regional_src = $urandom;
      fabric_cell_ce = $urandom;
      alt_pin_in = k[0];
      local_is_top_bottom = k[0];
      pll_fifth_output_clock = (k != 2);
      pll_fifth_to_top = k[1];
      for (j = 0; j < 16; j++) local_pick[j*6+:6] = $urandom;
      for (j = 0; j < 14; j++) tb_if_pick[j*5+:5] = $urandom;
      for (j = 0; j < 4; j++) lr_if_pick[j*6+:6] = $urandom;
      if (k[0]) lr_if_pick[18+:6] = 6'h2a;
      cyc(6);
      for (j = 0; j < 14; j++) chk(tb_if_clk[j], global_src[tb_if_pick[j*5+:5]]);
      chk(tb_if_clk[15:14], fabric_src[1:0]);
      for (j = 0; j < 4; j++) chk(lr_if_clk[j], lr_pick(j, lr_if_pick[j*6+:6]));
      chk(global_tree_on, global_tree_enable);
      chk(cell_ce, fabric_cell_ce);
      chk({regional_top_pll, regional_bottom_pll, pll_ref_clk},
          {pll_fifth_output_clock & k[1], pll_fifth_output_clock & !k[1], k[0]});
      for (j = 0; j < 16; j++) chk(local_net[j], pick(local_pick[j*6+:6]));
    end
    mux_enable = 8'hff;
    for (k = 0; k < 8; k++) begin
      for (j = 0; j < 8; j++) exp_sel[j] = (k < 4) ? (k + j) % 4 : $urandom_range(3, 0);
      for (j = 0; j < 8; j++) begin
        mux_sel[j*2+:2] = exp_sel[j];
        sw_mask[j] = (exp_sel[j] != prev_sel[j]);
        prev_sel[j] = exp_sel[j];
      end
      wait_idle(sw_mask);
      for (j = 0; j < 8; j++) chk(mux_active_sel[j*2+:2], exp_sel[j]);
      chk(mux_clk_en, 8'hff);
    end
    mux_enable = 8'h00;
    for (j = 0; j < 8; j++) sw_mask[j] = (prev_sel[j] != 0);
    wait_idle(sw_mask);
    chk(mux_active_sel, 16'h0000);
    print_verdict();
  end
  initial begin
    cyc(20000);
    n_fail++;
    print_verdict();
  end
endmodule // test_clock_network_dynamic_mux
`default_nettype wire
